// [design/uart_modem_defines.svh]
// Register offsets, field positions, reset values and widths of the modem handshake block.
`ifndef UART_MODEM_DEFINES_SVH
`define UART_MODEM_DEFINES_SVH

`define MODEM_CTRL_OFFSET   8'h00
`define INT_ENABLE_OFFSET   8'h04
`define MODEM_STATUS_OFFSET 8'h08
`define EVENT_STATUS_OFFSET 8'h0c
`define EVENT_MASK_OFFSET   8'h10

`define MCR_DTR_BIT         0
`define MCR_RTS_BIT         1
`define MCR_LOOP_BIT        4
`define IER_MODEM_BIT       3

`define MSR_CTS_DELTA_BIT   0
`define MSR_DSR_DELTA_BIT   1
`define MSR_RI_DELTA_BIT    2
`define MSR_DCD_DELTA_BIT   3
`define MSR_LEVEL_LSB       4

`define MODEM_CTRL_RESET    8'h00
`define INT_ENABLE_RESET    8'h00
`define EVENT_MASK_RESET    4'hf
`define LINE_IDLE_LEVEL     1'b1
`define LINE_COUNT          4

`endif

// [design/uart_modem_pkg.sv]
// Types shared by the modem handshake block.
package uart_modem_pkg;

  typedef struct packed {
    logic loopMode;
    logic requestSend;
    logic terminalReady;
  } modem_ctrl_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [31:0] wdata;
  } apb_req_s;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ACCESS = 2'b01
  } apb_state_e;

endpackage : uart_modem_pkg

// [design/line_sync.sv]
// Two-flop synchroniser with rise and change detection for one handshake input.
`timescale 1ns/1ns
`include "uart_modem_defines.svh"

module line_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Raw pin and synchronised results.
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      change
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pinIn};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_reg <= {3{`LINE_IDLE_LEVEL}};
    end else begin
      stage_reg <= stage_next;
    end
  end

  // Only the second and third stages feed logic; the first is metastability guard.
  assign level  = stage_reg[1];
  assign rise   = stage_reg[1] & ~stage_reg[2];
  assign change = stage_reg[1] ^ stage_reg[2];

endmodule : line_sync

// [design/uart_modem_handshake.sv]
// Modem handshake logic of a serial port with APB register access.
// Overview of operation
// - Status bit 5 shows inverted data-set-ready.
// - Status bit 1 flags data-set-ready rising.
// - Interrupt enable bit 3 raises change interrupt.
// - Status bit 4 shows inverted clear-to-send.
// - Status bit 0 flags clear-to-send rising.
// - Clear-to-send never gates transmission.
// - Control bit 1 drives request-to-send.
// - Reset leaves request-to-send high.
// - Loop mode holds request-to-send inactive.
// - Control bit 0 drives terminal-ready.
// - Reset leaves terminal-ready high.
// - Loop mode holds terminal-ready inactive.
// - Ring-indicate level bit 6, flag bit 2.
// - Carrier-detect level bit 7, flag bit 3.
`timescale 1ns/1ns
`include "uart_modem_defines.svh"

module uart_modem_handshake (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Modem handshake pins.
  input  wire logic        clear_to_send_n,
  input  wire logic        data_set_ready_n,
  input  wire logic        ring_indicate_n,
  input  wire logic        carrier_detect_n,
  output logic             request_to_send_n,
  output logic             terminal_ready_n,
  // Interrupt.
  output logic             irq
);

  localparam int N = `LINE_COUNT;

  // Synchronised lines, index order matches status flag order.
  logic [N-1:0] pins;
  logic [N-1:0] lineLevel;
  logic [N-1:0] lineRise;
  logic [N-1:0] lineChange;

  assign pins = {carrier_detect_n, ring_indicate_n, data_set_ready_n, clear_to_send_n};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_line
      line_sync u_sync (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (pins[gi]),
        .level  (lineLevel[gi]),
        .rise   (lineRise[gi]),
        .change (lineChange[gi])
      );
    end
  endgenerate

  function automatic logic isOffset(input logic [7:0] a, input logic [7:0] off);
    isOffset = (a == off);
  endfunction : isOffset

  function automatic logic mapped(input logic [7:0] a);
    mapped = isOffset(a, `MODEM_CTRL_OFFSET) | isOffset(a, `INT_ENABLE_OFFSET) |
             isOffset(a, `MODEM_STATUS_OFFSET) | isOffset(a, `EVENT_STATUS_OFFSET) |
             isOffset(a, `EVENT_MASK_OFFSET);
  endfunction : mapped

  // Drops only the flags that the answered read showed; an edge in the same cycle still sets its flag.
  function automatic logic [N-1:0] clearReported(input logic [N-1:0] flags, input logic [N-1:0] shown,
                                                 input logic hit, input logic [N-1:0] fresh);
    clearReported = (hit ? (flags & ~shown) : flags) | fresh;
  endfunction : clearReported

  // Read data of one register, zero above its used bits.
  function automatic logic [31:0] readValue(input logic [7:0] a, input logic [7:0] ctrl,
                                            input logic [7:0] inten, input logic [7:0] status,
                                            input logic [N-1:0] events, input logic [N-1:0] mask);
    logic [31:0] value;
    value = 32'h0000_0000;
    case (a)
      `MODEM_CTRL_OFFSET:   value = {24'h00_0000, ctrl};
      `INT_ENABLE_OFFSET:   value = {24'h00_0000, inten};
      `MODEM_STATUS_OFFSET: value = {24'h00_0000, status};
      `EVENT_STATUS_OFFSET: value = {28'h000_0000, events};
      `EVENT_MASK_OFFSET:   value = {28'h000_0000, mask};
      default:              value = 32'h0000_0000;
    endcase
    readValue = value;
  endfunction : readValue

  uart_modem_pkg::apb_req_s   req;
  uart_modem_pkg::apb_state_e state_reg;
  uart_modem_pkg::apb_state_e state_next;
  uart_modem_pkg::modem_ctrl_s ctrlView;

  logic [7:0]   modemCtrl_reg;
  logic [7:0]   modemCtrl_next;
  logic [7:0]   intEnable_reg;
  logic [7:0]   intEnable_next;
  logic [N-1:0] delta_reg;
  logic [N-1:0] delta_next;
  logic [N-1:0] event_reg;
  logic [N-1:0] event_next;
  logic [N-1:0] mask_reg;
  logic [N-1:0] mask_next;
  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic         pready_reg;
  logic         pready_next;
  logic         pslverr_reg;
  logic         pslverr_next;
  logic         rts_reg;
  logic         rts_next;
  logic         dtr_reg;
  logic         dtr_next;
  logic         irq_reg;
  logic         irq_next;
  logic [7:0]   statusView;
  logic         done;
  logic         writeDone;
  logic         readDone;
  logic         ctrlWrite;
  logic         intEnWrite;
  logic         maskWrite;
  logic         statusRead;
  logic         eventRead;
  logic [N-1:0] shownFlags;

  assign req      = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign done     = psel & penable & pready_reg;
  assign ctrlView = '{loopMode:      modemCtrl_reg[`MCR_LOOP_BIT],
                      requestSend:   modemCtrl_reg[`MCR_RTS_BIT],
                      terminalReady: modemCtrl_reg[`MCR_DTR_BIT]};

  // Access strobes, valid in the cycle that ends the access.
  assign writeDone  = done & req.write;
  assign readDone   = done & ~req.write;
  assign ctrlWrite  = writeDone & isOffset(req.addr, `MODEM_CTRL_OFFSET);
  assign intEnWrite = writeDone & isOffset(req.addr, `INT_ENABLE_OFFSET);
  assign maskWrite  = writeDone & isOffset(req.addr, `EVENT_MASK_OFFSET);
  assign statusRead = readDone & isOffset(req.addr, `MODEM_STATUS_OFFSET);
  assign eventRead  = readDone & isOffset(req.addr, `EVENT_STATUS_OFFSET);
  assign shownFlags = prdata_reg[N-1:0];

  // Upper nibble shows inverted levels, lower nibble the rise flags.
  assign statusView = {~lineLevel, delta_reg};

  // Bus answer: read data is captured at the setup edge and stands through the access cycle.
  always_comb begin
    state_next   = state_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    case (state_reg)
      uart_modem_pkg::APB_IDLE: begin
        if (psel && !penable) begin
          state_next   = uart_modem_pkg::APB_ACCESS;
          pready_next  = 1'b1;
          pslverr_next = ~mapped(req.addr);
          prdata_next  = 32'h0000_0000;
          if (!req.write) begin
            prdata_next = readValue(req.addr, modemCtrl_reg, intEnable_reg, statusView, event_reg, mask_reg);
          end
        end
      end
      uart_modem_pkg::APB_ACCESS: begin
        state_next = uart_modem_pkg::APB_IDLE;
      end
      default: begin
        state_next = uart_modem_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= uart_modem_pkg::APB_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Modem control register.
  always_comb begin
    modemCtrl_next = modemCtrl_reg;
    if (ctrlWrite) begin
      modemCtrl_next = req.wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modemCtrl_reg <= `MODEM_CTRL_RESET;
    end else begin
      modemCtrl_reg <= modemCtrl_next;
    end
  end

  // Interrupt enable register.
  always_comb begin
    intEnable_next = intEnable_reg;
    if (intEnWrite) begin
      intEnable_next = req.wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intEnable_reg <= `INT_ENABLE_RESET;
    end else begin
      intEnable_reg <= intEnable_next;
    end
  end

  // Event mask register.
  always_comb begin
    mask_next = mask_reg;
    if (maskWrite) begin
      mask_next = req.wdata[N-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= `EVENT_MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Rise flags of the modem status register; new edges win over a clearing read.
  always_comb begin
    delta_next = clearReported(delta_reg, shownFlags, statusRead, lineRise);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delta_reg <= '0;
    end else begin
      delta_reg <= delta_next;
    end
  end

  // Change flags of the event status register.
  always_comb begin
    event_next = clearReported(event_reg, shownFlags, eventRead, lineChange);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_reg <= '0;
    end else begin
      event_reg <= event_next;
    end
  end

  // Handshake outputs; clear-to-send only reaches status and gates nothing here.
  always_comb begin
    rts_next = ~(ctrlView.requestSend & ~ctrlView.loopMode);
    dtr_next = ~(ctrlView.terminalReady & ~ctrlView.loopMode);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rts_reg <= 1'b1;
      dtr_reg <= 1'b1;
    end else begin
      rts_reg <= rts_next;
      dtr_reg <= dtr_next;
    end
  end

  // Level interrupt.
  always_comb begin
    irq_next = intEnable_reg[`IER_MODEM_BIT] & (|(event_reg & mask_reg));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign request_to_send_n = rts_reg;
  assign terminal_ready_n  = dtr_reg;
  assign irq               = irq_reg;

endmodule : uart_modem_handshake

// [sim/modem_model.sv]
// External modem model that drives the four active-low handshake lines.
`timescale 1ns/1ns
module modem_model (
  // Lines the modem asserts, and the pins it drives.
  input  wire logic [3:0] assertLines,
  output logic [3:0]      linesN
);
  assign linesN = ~assertLines;
endmodule : modem_model

// [sim/uart_modem_handshake_sva.sv]
// Port checker of the modem handshake block.
`timescale 1ns/1ns
module uart_modem_handshake_sva (
  input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        clear_to_send_n, data_set_ready_n, ring_indicate_n, carrier_detect_n,
  input wire logic        request_to_send_n, terminal_ready_n
);
  logic [3:0] pins, pinsD, calm;
  logic       acc, ctlWr;
  assign pins = {carrier_detect_n, ring_indicate_n, data_set_ready_n, clear_to_send_n};
  assign acc = psel && penable && pready;
  assign ctlWr = acc && pwrite && paddr == 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinsD <= 4'hf;
      calm <= 4'h0;
    end else begin
      pinsD <= pins;
      calm <= (pins != pinsD) ? 4'h0 : ((calm == 4'hf) ? calm : calm + 4'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_ready; s_setup |=> s_answer; endproperty
  property p_errOnly; pslverr |-> pready; endproperty
  property p_unmapped;
    acc && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |-> pslverr && prdata == 32'h0;
  endproperty
  property p_reset;
    @(posedge clk) disable iff (1'b0) rst |-> request_to_send_n && terminal_ready_n && !irq;
  endproperty
  property p_ctl;
    ctlWr && !pwdata[4] |-> ##2 request_to_send_n == !$past(pwdata[1], 2)
      && terminal_ready_n == !$past(pwdata[0], 2);
  endproperty
  property p_loop; ctlWr && pwdata[4] |-> ##2 (request_to_send_n && terminal_ready_n) [*2]; endproperty
  property p_still; $changed(request_to_send_n) || $changed(terminal_ready_n) |-> $past(ctlWr, 2); endproperty
  property p_level; calm > 4'h5 && acc && !pwrite && paddr == 8'h08 |-> prdata[7:4] == ~pins; endproperty
  property p_irqDrop; $fell(irq) |-> $past(acc, 2); endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
  a_errOnly: assert property (p_errOnly) else $error("pslverr without pready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_reset: assert property (p_reset) else $error("outputs not inactive in reset");
  a_ctl: assert property (p_ctl) else $error("control bits not on pins");
  a_loop: assert property (p_loop) else $error("loop mode left pins active");
  a_still: assert property (p_still) else $error("pin changed without control write");
  a_level: assert property (p_level) else $error("status levels not inverted pins");
  a_irqDrop: assert property (p_irqDrop) else $error("irq fell without access");
endmodule : uart_modem_handshake_sva
bind uart_modem_handshake uart_modem_handshake_sva sva_inst (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .irq(irq), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .clear_to_send_n(clear_to_send_n), .data_set_ready_n(data_set_ready_n),
  .ring_indicate_n(ring_indicate_n), .carrier_detect_n(carrier_detect_n),
  .request_to_send_n(request_to_send_n), .terminal_ready_n(terminal_ready_n));

// [sim/tb_uart_modem_handshake.sv]
// Testbench of the modem handshake block.
`timescale 1ns/1ns
module tb_uart_modem_handshake;
  logic        clk = 1'b0, rst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, irq, rts, dtr, rerr;
  logic [3:0]  act = 4'h0, linesN;
  logic [4:0]  mv [4] = '{5'h03, 5'h13, 5'h02, 5'h01};
  int          nFail = 0, checkCount = 0;
  always #50 clk = ~clk;
  uart_modem_handshake uart_modem_handshake_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_to_send_n(linesN[0]), .data_set_ready_n(linesN[1]), .ring_indicate_n(linesN[2]),
    .carrier_detect_n(linesN[3]), .request_to_send_n(rts), .terminal_ready_n(dtr), .irq(irq));
  modem_model modem_model_inst (.assertLines(act), .linesN(linesN));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    report_and_stop();
  end
  initial begin
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk("rtsN", 32'h1, {31'h0, rts});
    chk("dtrN", 32'h1, {31'h0, dtr});
    xfer(1'b0, 8'h10, 32'h0); chk("mask", 32'hf, rdata);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h00, {27'h0, mv[i]});
      settle();
      chk("rtsN", {31'h0, ~(mv[i][1] & ~mv[i][4])}, {31'h0, rts});
      chk("dtrN", {31'h0, ~(mv[i][0] & ~mv[i][4])}, {31'h0, dtr});
    end
    xfer(1'b0, 8'h00, 32'h0); chk("ctrl", 32'h1, rdata);
    xfer(1'b1, 8'h04, 32'h8);
    for (int i = 0; i < 4; i++) begin
      act <= 4'h1 << i;
      settle(); chk("irqSet", 32'h1, {31'h0, irq});
      chk("rtsHeld", 32'h1, {31'h0, rts});
      chk("dtrHeld", 32'h0, {31'h0, dtr});
      xfer(1'b0, 8'h08, 32'h0); chk("level", 32'h10 << i, rdata);
      xfer(1'b0, 8'h0c, 32'h0); chk("event", 32'h1 << i, rdata);
      repeat (2) @(negedge clk);
      chk("irqClr", 32'h0, {31'h0, irq});
      @(posedge clk);
      act <= 4'h0;
      settle();
      xfer(1'b0, 8'h08, 32'h0); chk("rise", 32'h1 << i, rdata);
      xfer(1'b0, 8'h08, 32'h0); chk("cleared", 32'h0, rdata);
      xfer(1'b0, 8'h0c, 32'h0);
    end
    xfer(1'b1, 8'h10, 32'h0);
    act <= 4'h2;
    settle(); chk("masked", 32'h0, {31'h0, irq});
    xfer(1'b1, 8'h10, 32'hf);
    settle(); chk("unmasked", 32'h1, {31'h0, irq});
    xfer(1'b1, 8'h04, 32'h0);
    settle(); chk("disabled", 32'h0, {31'h0, irq});
    xfer(1'b0, 8'h20, 32'h0); chk("err", 32'h1, {31'h0, rerr}); chk("errData", 32'h0, rdata);
    report_and_stop();
  end
endmodule : tb_uart_modem_handshake
